// ---- logic/sra_status_regs.sv ----
// Status register bank with direct and indirect serial access
`timescale 1ns/10ps
module sra_status_regs #(
   parameter int NUM_REGS = sra_pkg::NUM_REGS
) (
   // Clock and resets
   input  wire logic                 mclk,
   input  wire logic                 nrst,
   input  wire logic                 por_n,
   // Serial pins
   input  wire sra_pkg::sra_spi_in_t spi,
   output logic                      so,
   output logic                      so_oe,
   // Protection inputs
   input  wire logic                 wp_n,
   input  wire logic                 status_protect_high,
   // Status outputs
   output sra_pkg::sra_prot_t        prot,
   output logic                      write_enable_latch,
   output logic                      ready
);

   localparam int LOAD_MAX = 6;
   localparam sra_pkg::sra_idx_t LAST_IDX = sra_pkg::sra_idx_t'(NUM_REGS - 1);

   // Register state
   logic [NUM_REGS-1:0][7:0] sreg_ff;
   logic [NUM_REGS-1:0][7:0] view;
   sra_pkg::sra_state_t      st_ff;
   sra_pkg::sra_state_t      nxt_st;
   sra_pkg::sra_idx_t        load_idx_ff;
   sra_pkg::sra_idx_t        tgt_idx_ff;
   logic                     tgt_ok_ff;
   logic                     rd_mode_ff;
   logic                     wel_ff;
   logic                     vwe_ff;
   logic [7:0]               rd_data_ff;

   // Byte engine and store wires
   logic [7:0]               rx_byte;
   logic                     rx_valid;
   logic                     so_bit;
   logic [7:0]               nv_rd;

   // Decode wires
   logic                     in_cmd;
   logic                     in_addr;
   logic                     in_wdata;
   logic                     op_rd_dir;
   logic                     op_wr_dir;
   sra_pkg::sra_idx_t        op_dir_idx;
   logic                     addr_ok;
   sra_pkg::sra_idx_t        addr_idx;
   logic                     wen;
   logic                     wr_go;
   logic                     nv_wr;
   logic                     loading;
   logic [7:0]               rd_view;

   sra_spi_shift #(
      .BYTE_W (sra_pkg::BYTE_W)
   ) u_shift (
      .mclk     (mclk),
      .nrst     (nrst),
      .spi      (spi),
      .so_bit   (so_bit),
      .tx_byte  (rd_data_ff),
      .rx_byte  (rx_byte),
      .rx_valid (rx_valid)
   );

   sra_nv_store #(
      .NUM_REGS (NUM_REGS)
   ) u_nv (
      .mclk    (mclk),
      .por_n   (por_n),
      .wr_en   (nv_wr),
      .wr_idx  (tgt_idx_ff),
      .wr_data (rx_byte),
      .rd_idx  (load_idx_ff),
      .rd_data (nv_rd)
   );

   // Byte classification per state
   assign loading  = (st_ff == sra_pkg::ST_LOAD);
   assign in_cmd   = (st_ff == sra_pkg::ST_CMD) && rx_valid;
   assign in_addr  = (st_ff == sra_pkg::ST_ADDR) && rx_valid;
   assign in_wdata = (st_ff == sra_pkg::ST_WDATA) && rx_valid;

   // Direct opcodes only reach the first three registers
   assign op_rd_dir  = (rx_byte == sra_pkg::OP_RD_SR1) || (rx_byte == sra_pkg::OP_RD_SR2) ||
                       (rx_byte == sra_pkg::OP_RD_SR3);
   assign op_wr_dir  = (rx_byte == sra_pkg::OP_WR_SR1) || (rx_byte == sra_pkg::OP_WR_SR2) ||
                       (rx_byte == sra_pkg::OP_WR_SR3);
   assign op_dir_idx = ((rx_byte == sra_pkg::OP_RD_SR1) || (rx_byte == sra_pkg::OP_WR_SR1)) ?
                          3'h0 :
                       ((rx_byte == sra_pkg::OP_RD_SR2) || (rx_byte == sra_pkg::OP_WR_SR2)) ?
                          3'h1 : 3'h2;

   // Full 8-bit compare, so e.g. 81h never aliases onto register one
   assign addr_ok  = (rx_byte >= sra_pkg::ADDR_FIRST) && (rx_byte <= sra_pkg::ADDR_LAST);
   assign addr_idx = sra_pkg::sra_idx_t'(rx_byte - sra_pkg::ADDR_FIRST);

   // Write gating; the volatile enable does not raise the latch
   assign wen   = wel_ff | vwe_ff;
   assign wr_go = in_wdata && wen && tgt_ok_ff;
   assign nv_wr = wr_go && wel_ff;

   // State sequencing; chip select high returns to opcode phase in every state but copy-in
   always_comb begin
      nxt_st = st_ff;
      if (loading) begin
         if (load_idx_ff == LAST_IDX) begin
            nxt_st = sra_pkg::ST_CMD;
         end
      end else if (spi.cs_n) begin
         nxt_st = sra_pkg::ST_CMD;
      end else if (rx_valid) begin
         unique case (st_ff)
            sra_pkg::ST_CMD: begin
               if (op_rd_dir) begin
                  nxt_st = sra_pkg::ST_READ;
               end else if (op_wr_dir) begin
                  nxt_st = sra_pkg::ST_WDATA;
               end else if ((rx_byte == sra_pkg::OP_RD_IND) ||
                            (rx_byte == sra_pkg::OP_WR_IND)) begin
                  nxt_st = sra_pkg::ST_ADDR;
               end else begin
                  nxt_st = sra_pkg::ST_IGNORE;
               end
            end
            sra_pkg::ST_ADDR: begin
               nxt_st = rd_mode_ff ? sra_pkg::ST_READ : sra_pkg::ST_WDATA;
            end
            sra_pkg::ST_WDATA: begin
               nxt_st = sra_pkg::ST_IGNORE;
            end
            sra_pkg::ST_READ: begin
               nxt_st = sra_pkg::ST_READ;
            end
            sra_pkg::ST_IGNORE: begin
               nxt_st = sra_pkg::ST_IGNORE;
            end
            sra_pkg::ST_LOAD: begin
               nxt_st = sra_pkg::ST_LOAD;
            end
         endcase
      end
   end

   // Reset restarts the copy-in from the stored set
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_ff       <= sra_pkg::ST_LOAD;
         load_idx_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         if (loading) begin
            load_idx_ff <= load_idx_ff + 3'h1;
         end
      end
   end

   // Target register and access direction
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tgt_idx_ff <= '0;
         tgt_ok_ff  <= 1'b0;
         rd_mode_ff <= 1'b0;
      end else if (in_cmd) begin
         tgt_idx_ff <= op_dir_idx;
         tgt_ok_ff  <= op_rd_dir | op_wr_dir;
         rd_mode_ff <= (rx_byte == sra_pkg::OP_RD_IND);
      end else if (in_addr) begin
         tgt_idx_ff <= addr_idx;
         tgt_ok_ff  <= addr_ok;
      end
   end

   // Enables: armed by their opcodes, spent by the data byte of a write
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wel_ff <= 1'b0;
         vwe_ff <= 1'b0;
      end else if (in_cmd && (rx_byte == sra_pkg::OP_WREN)) begin
         wel_ff <= 1'b1;
      end else if (in_cmd && (rx_byte == sra_pkg::OP_VWREN)) begin
         vwe_ff <= 1'b1;
      end else if (in_wdata && wen) begin
         wel_ff <= 1'b0;
         vwe_ff <= 1'b0;
      end
   end

   // Live registers: copy-in first, then writes; reset clears them
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_sreg
      localparam logic [7:0] KEEP = (g == 0) ? ~sra_pkg::SR1_RO_MASK : 8'hFF;
      always_ff @(posedge mclk) begin
         if (!nrst) begin
            sreg_ff[g] <= sra_pkg::REG_RESET;
         end else if (loading && (int'(load_idx_ff) == g)) begin
            sreg_ff[g] <= nv_rd & KEEP;
         end else if (wr_go && (int'(tgt_idx_ff) == g)) begin
            sreg_ff[g] <= rx_byte & KEEP;
         end
      end
      if (g == 0) begin : g_view_one
         assign view[g] = {sreg_ff[g][7:2], wel_ff, sra_pkg::BUSY_VALUE};
      end else begin : g_view_rest
         assign view[g] = sreg_ff[g];
      end
   end

   // Read value refreshed every cycle, so a held read keeps polling
   assign rd_view = tgt_ok_ff ? view[tgt_idx_ff] : sra_pkg::UNMAPPED_RD;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rd_data_ff <= sra_pkg::UNMAPPED_RD;
      end else begin
         rd_data_ff <= rd_view;
      end
   end

   // Output drives only while a read is under way
   assign so    = so_bit;
   assign so_oe = (st_ff == sra_pkg::ST_READ) && !spi.cs_n;
   assign ready = !loading;
   assign write_enable_latch = wel_ff;

   // Protection fields from register one and the protect inputs
   assign prot.status_protect_high    = status_protect_high;
   assign prot.status_protect_low     = sreg_ff[0][sra_pkg::BIT_PROT_LOW];
   assign prot.wp_n                   = wp_n;
   assign prot.protect_granule_select = sreg_ff[0][sra_pkg::BIT_GRANULE];
   assign prot.protect_direction      = sreg_ff[0][sra_pkg::BIT_DIRECTION];
   assign prot.block_protect_field    = sreg_ff[0][sra_pkg::BIT_BP_HI:sra_pkg::BIT_BP_LO];
   // Pin only counts with low bit set and high bit clear
   assign prot.status_hw_locked       = sreg_ff[0][sra_pkg::BIT_PROT_LOW] &
                                        ~status_protect_high & ~wp_n;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence cmd_byte_s(logic [7:0] op);
      in_cmd && (rx_byte == op);
   endsequence

   sequence addr_byte_s;
      in_addr && addr_ok;
   endsequence

   sequence ind_rd_s(logic [7:0] a);
      in_addr && rd_mode_ff && (rx_byte == a);
   endsequence

   load_bounded_a: assert property (
      loading |-> ##[1:LOAD_MAX] !loading)
      else $error("copy-in did not finish in time");

   load_copy_a: assert property (
      (loading && (load_idx_ff == LAST_IDX)) |=> (sreg_ff[NUM_REGS-1] == $past(nv_rd)))
      else $error("last register not loaded from stored copy");

   direct_read_a: assert property (
      cmd_byte_s(sra_pkg::OP_RD_SR2) |=> (st_ff == sra_pkg::ST_READ) ##1
         (rd_data_ff == $past(view[1])))
      else $error("direct read of register two wrong");

   direct_range_a: assert property (
      (in_cmd && op_wr_dir) |=> (int'(tgt_idx_ff) < sra_pkg::DIRECT_REGS) && tgt_ok_ff)
      else $error("direct write aimed past third register");

   write_refused_a: assert property (
      (in_wdata && !wen) |=> $stable(sreg_ff))
      else $error("write accepted without enable");

   volatile_only_a: assert property (
      (wr_go && vwe_ff && !wel_ff) |-> !nv_wr ##1 !wel_ff && !vwe_ff)
      else $error("volatile write touched stored copy");

   indirect_decode_a: assert property (
      addr_byte_s |=> tgt_ok_ff && (tgt_idx_ff == $past(addr_idx)) &&
         (int'(tgt_idx_ff) == int'($past(rx_byte)) - 1))
      else $error("indirect address decoded wrongly");

   unmapped_write_a: assert property (
      (in_wdata && !tgt_ok_ff) |=> $stable(sreg_ff))
      else $error("write to undefined address changed a register");

   unmapped_read_a: assert property (
      ((st_ff == sra_pkg::ST_READ) && !tgt_ok_ff && !spi.cs_n) |=>
         (rd_data_ff == sra_pkg::UNMAPPED_RD))
      else $error("undefined address read not fixed value");

   granule_write_a: assert property (
      (wr_go && (tgt_idx_ff == 3'h0)) |=>
         (prot.protect_granule_select == $past(rx_byte[sra_pkg::BIT_GRANULE])) &&
         (prot.protect_direction == $past(rx_byte[sra_pkg::BIT_DIRECTION])))
      else $error("register one protect fields not updated");

   nv_both_a: assert property (
      (wr_go && wel_ff) |-> nv_wr ##1 (sreg_ff[tgt_idx_ff] ==
         ($past(rx_byte) & (tgt_idx_ff == 3'h0 ? ~sra_pkg::SR1_RO_MASK : 8'hFF))))
      else $error("enabled write missed live or stored copy");

   // Reset leaves live registers and enables clear while copy-in is pending
   reset_clear_a: assert property (
      $rose(nrst) |-> (sreg_ff == {NUM_REGS{sra_pkg::REG_RESET}}) && !write_enable_latch &&
         !ready)
      else $error("live state not cleared by reset");

   wel_set_a: assert property (
      cmd_byte_s(sra_pkg::OP_WREN) |=> write_enable_latch)
      else $error("write enable opcode did not set latch");

   vol_enable_a: assert property (
      cmd_byte_s(sra_pkg::OP_VWREN) |=> vwe_ff && (write_enable_latch == $past(wel_ff)))
      else $error("volatile enable opcode disturbed latch");

   enable_spent_a: assert property (
      (in_wdata && wen) |=> !write_enable_latch && !vwe_ff)
      else $error("enable survived a write data byte");

   reg_two_write_a: assert property (
      (wr_go && (tgt_idx_ff == 3'h1)) |=> (sreg_ff[1] == $past(rx_byte)))
      else $error("register two not loaded from data byte");

   // Stored copy is checked inside the store, not only through the reload path
   stored_copy_a: assert property (
      (wr_go && wel_ff) |=> (u_nv.nv_ff[tgt_idx_ff] == $past(rx_byte)))
      else $error("stored copy missed an enabled write");

   stored_kept_a: assert property (
      (wr_go && !wel_ff) |=> $stable(u_nv.nv_ff))
      else $error("volatile write changed stored copy");

   addr_full_a: assert property (
      (in_addr && rx_byte[sra_pkg::BYTE_W-1]) |=> !tgt_ok_ff)
      else $error("address with top bit set selected a register");

   ind_read_a: assert property (
      ind_rd_s(sra_pkg::ADDR_LAST) |=> ##1 (rd_data_ff == $past(view[NUM_REGS-1])))
      else $error("indirect read of last register wrong");

   oe_on_read_a: assert property (
      (in_addr && rd_mode_ff && !spi.cs_n) |=> (so_oe || spi.cs_n))
      else $error("output not enabled for indirect read");

endmodule

// ---- logic/sra_pkg.sv ----
// Constants, types and field layout for the status register access block
// Notes on behaviour
// - All six status registers are reachable indirectly, only the first three by their own opcodes.
// - Read opcodes 05h, 35h and 15h return status registers one, two and three.
// - Write opcodes 01h, 31h and 11h load status registers one, two and three from the next byte.
// - Opcode 65h followed by an address byte returns the selected status register.
// - Opcode 71h followed by an address byte and a data byte updates the selected register.
// - Address values 01h to 06h select status registers one to six in order.
// - A write enabled by opcode 50h changes only the live registers, not the stored copy.
// - A write enabled by opcode 06h changes both the live registers and the stored copy.
// - After power-up every live register is loaded from its stored copy before commands run.
// - Bit 7 of register one is a protect control bit that joins a companion bit and the pin.
// - Bit 6 of register one picks the protect granule, 64 kB when 0 and 4 kB when 1.
// - Bit 5 of register one picks the protect direction, bottom up when 0 and top down when 1.
// - The indirect address is decoded over all 8 bits.
// - Status register writes are refused while no write enable is armed.
// - Live registers are cleared by reset while the stored copy survives it.
package sra_pkg;

   // Register file shape
   localparam int NUM_REGS    = 6;
   localparam int DIRECT_REGS = 3;
   localparam int BYTE_W      = 8;

   // Opcodes
   localparam logic [7:0] OP_RD_SR1 = 8'h05;
   localparam logic [7:0] OP_RD_SR2 = 8'h35;
   localparam logic [7:0] OP_RD_SR3 = 8'h15;
   localparam logic [7:0] OP_WR_SR1 = 8'h01;
   localparam logic [7:0] OP_WR_SR2 = 8'h31;
   localparam logic [7:0] OP_WR_SR3 = 8'h11;
   localparam logic [7:0] OP_RD_IND = 8'h65;
   localparam logic [7:0] OP_WR_IND = 8'h71;
   localparam logic [7:0] OP_WREN   = 8'h06;
   localparam logic [7:0] OP_VWREN  = 8'h50;

   // Indirect address range
   localparam logic [7:0] ADDR_FIRST = 8'h01;
   localparam logic [7:0] ADDR_LAST  = 8'h06;

   // Register one field positions
   localparam int BIT_PROT_LOW  = 7;
   localparam int BIT_GRANULE   = 6;
   localparam int BIT_DIRECTION = 5;
   localparam int BIT_BP_HI     = 4;
   localparam int BIT_BP_LO     = 2;
   localparam int BIT_WEL       = 1;
   localparam int BIT_BUSY      = 0;

   // Values
   localparam logic [7:0] SR1_RO_MASK = 8'h03;
   localparam logic [7:0] REG_RESET   = 8'h00;
   localparam logic [7:0] NV_DEFAULT  = 8'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;
   localparam logic       BUSY_VALUE  = 1'b0;

   typedef logic [2:0] sra_idx_t;

   typedef enum logic [2:0] {
      ST_LOAD,
      ST_CMD,
      ST_ADDR,
      ST_WDATA,
      ST_READ,
      ST_IGNORE
   } sra_state_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
   } sra_spi_in_t;

   typedef struct packed {
      logic       status_protect_high;
      logic       status_protect_low;
      logic       wp_n;
      logic       protect_granule_select;
      logic       protect_direction;
      logic [2:0] block_protect_field;
      logic       status_hw_locked;
   } sra_prot_t;

endpackage

// ---- logic/sra_nv_store.sv ----
// Nonvolatile copy of the status registers, kept across device reset
`timescale 1ns/10ps
module sra_nv_store #(
   parameter int NUM_REGS = sra_pkg::NUM_REGS
) (
   // Clock and power-on clear
   input  wire logic               mclk,
   input  wire logic               por_n,
   // Write port
   input  wire logic               wr_en,
   input  wire sra_pkg::sra_idx_t  wr_idx,
   input  wire logic [7:0]         wr_data,
   // Read port
   input  wire sra_pkg::sra_idx_t  rd_idx,
   output logic [7:0]              rd_data
);

   logic [NUM_REGS-1:0][7:0] nv_ff;

   // Only power-on clears the copy; device reset leaves it alone
   always_ff @(posedge mclk) begin
      if (!por_n) begin
         nv_ff <= {NUM_REGS{sra_pkg::NV_DEFAULT}};
      end else if (wr_en) begin
         nv_ff[wr_idx] <= wr_data;
      end
   end

   // Out-of-range read index gives the default value
   assign rd_data = (int'(rd_idx) < NUM_REGS) ? nv_ff[rd_idx] : sra_pkg::NV_DEFAULT;

endmodule

// ---- logic/sra_spi_shift.sv ----
// Serial byte engine: shifts bytes in on sck rise and out on sck fall
`timescale 1ns/10ps
module sra_spi_shift #(
   parameter int BYTE_W = sra_pkg::BYTE_W
) (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               nrst,
   // Serial pins
   input  wire sra_pkg::sra_spi_in_t spi,
   output logic                    so_bit,
   // Byte side
   input  wire logic [BYTE_W-1:0]  tx_byte,
   output logic [BYTE_W-1:0]       rx_byte,
   output logic                    rx_valid
);

   localparam int CNT_W = $clog2(BYTE_W);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BYTE_W - 1);

   logic              sck_d_ff;
   logic [CNT_W-1:0]  cnt_ff;
   logic [BYTE_W-2:0] sh_ff;
   logic [BYTE_W-1:0] rx_ff;
   logic              rx_valid_ff;
   logic              load_ff;
   logic [BYTE_W-1:0] tx_ff;
   logic              rise;
   logic              fall;

   // Pins are synchronous, so plain edge detection on sck is enough
   assign rise = spi.sck & ~sck_d_ff & ~spi.cs_n;
   assign fall = ~spi.sck & sck_d_ff & ~spi.cs_n;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sck_d_ff <= 1'b0;
      end else begin
         sck_d_ff <= spi.sck;
      end
   end

   // Receive side; chip select high restarts byte framing
   always_ff @(posedge mclk) begin
      if (!nrst || spi.cs_n) begin
         cnt_ff      <= '0;
         sh_ff       <= '0;
         rx_valid_ff <= 1'b0;
      end else begin
         rx_valid_ff <= rise && (cnt_ff == CNT_LAST);
         if (rise) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
            sh_ff  <= {sh_ff[BYTE_W-3:0], spi.si};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rx_ff <= '0;
      end else if (rise && (cnt_ff == CNT_LAST)) begin
         rx_ff <= {sh_ff, spi.si};
      end
   end

   // Transmit side: new byte taken on the first fall after a byte ends
   always_ff @(posedge mclk) begin
      if (!nrst || spi.cs_n) begin
         load_ff <= 1'b0;
         tx_ff   <= '0;
      end else if (rise && (cnt_ff == CNT_LAST)) begin
         load_ff <= 1'b1;
      end else if (fall) begin
         load_ff <= 1'b0;
         tx_ff   <= load_ff ? tx_byte : {tx_ff[BYTE_W-2:0], 1'b0};
      end
   end

   assign rx_byte  = rx_ff;
   assign rx_valid = rx_valid_ff;
   assign so_bit   = tx_ff[BYTE_W-1];

endmodule

// ---- tb/sra_spi_host.sv ----
// Serial host model that frames status register commands for the device
`timescale 1ns/10ps
module sra_spi_host (
   // Clock
   input  wire logic            mclk,
   // Serial pins
   output sra_pkg::sra_spi_in_t spi,
   input  wire logic            so
);
   // Clock parked low between frames, select inactive
   initial spi = 3'b100;

   // Sends ntx bytes from the top of tx, then clocks in nrd bytes
   // Each phase lasts 5 cycles, since the device needs at least 3
   task automatic frame(input logic [23:0] tx, input int ntx, input int nrd,
                        output logic [15:0] rx);
      @(posedge mclk);
      #1 spi.cs_n = 1'b0;
      rx = '0;
      for (int i = 0; i < 8 * (ntx + nrd); i++) begin
         spi.si = (i < 8 * ntx) ? tx[23-i] : ~spi.si; // Idle data keeps moving
         repeat (5) @(posedge mclk);
         rx = {rx[14:0], so};
         #1 spi.sck = 1'b1;
         repeat (5) @(posedge mclk);
         #1 spi.sck = 1'b0;
      end
      repeat (5) @(posedge mclk);
      #1 spi.cs_n = 1'b1;
      spi.si = ~spi.si;
      repeat (4) @(posedge mclk);
   endtask
endmodule

// ---- tb/status_register_access_tb_top.sv ----
// Self-checking bench for the status register bank
`timescale 1ns/10ps
module status_register_access_tb_top;
   logic                 mclk = 1'b0;
   logic                 nrst = 1'b0;
   logic                 por_n = 1'b0;
   logic                 wp_n = 1'b0;
   logic                 status_protect_high = 1'b0;
   sra_pkg::sra_spi_in_t spi;
   logic                 so;
   logic                 so_oe;
   logic                 write_enable_latch;
   logic                 ready;
   sra_pkg::sra_prot_t   prot;
   int                   mismatches = 0;
   int                   checked = 0;
   int                   oe_cycles = 0;
   logic [15:0]          rx;
   logic [7:0]           vals [6] = '{8'h24, 8'h5A, 8'hC3, 8'h96, 8'h3C, 8'h7E};
   logic [7:0]           rds [3] = '{8'h05, 8'h35, 8'h15};
   logic [7:0]           wrs [3] = '{8'h01, 8'h31, 8'h11};

   // 20 MHz clock
   always #25 mclk = ~mclk;

   sra_status_regs dut_u (
      .mclk(mclk), .nrst(nrst), .por_n(por_n), .spi(spi), .so(so), .so_oe(so_oe),
      .wp_n(wp_n), .status_protect_high(status_protect_high), .prot(prot),
      .write_enable_latch(write_enable_latch), .ready(ready)
   );
   // Output reads inverted while not driven, so a missing enable corrupts reads
   sra_spi_host host_u (.mclk(mclk), .spi(spi), .so(so_oe ? so : ~so));

   // Counts edges at which the device drives its output
   always @(posedge mclk) oe_cycles <= oe_cycles + int'(so_oe);

   task automatic print_verdict();
      $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_prot(input sra_pkg::sra_prot_t got, input sra_pkg::sra_prot_t exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Register one reads its low bits as latch and idle busy, both 0 here
   function automatic logic [7:0] exp_of(input int i, input logic [7:0] v);
      return (i == 1) ? (v & 8'hFC) : v;
   endfunction

   // Holds reset 3 cycles, then counts edges until the copy-in completes
   task automatic do_reset();
      int n;
      @(posedge mclk);
      #1 nrst = 1'b0;
      repeat (3) @(posedge mclk);
      #1 nrst = 1'b1;
      por_n = 1'b1;
      n = 0;
      while (ready !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1 n++;
      end
      chk_byte(8'(n), 8'h06);
      if (ready !== 1'b1) begin
         mismatches++;
         print_verdict();
      end
   endtask

   task automatic send(input logic [7:0] op);
      host_u.frame({op, 16'h0000}, 1, 0, rx);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] en, input logic [7:0] v);
      send(en);
      host_u.frame({sra_pkg::OP_WR_IND, a, v}, 3, 0, rx);
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      host_u.frame({sra_pkg::OP_RD_IND, a, 8'h00}, 2, 1, rx);
      v = rx[7:0];
   endtask

   task automatic wr_dir(input int i, input logic [7:0] v);
      host_u.frame({wrs[i], v, 8'h00}, 2, 0, rx);
   endtask

   task automatic rd_dir(input int i, output logic [7:0] v);
      host_u.frame({rds[i], 16'h0000}, 1, 1, rx);
      v = rx[7:0];
   endtask

   // Main sequence of tests
   initial begin
      logic [7:0] v;
      int oe0;
      do_reset();
      chk_byte({6'h0, write_enable_latch, so_oe}, 8'h00);
      $display("test power_up done");
      // Stored writes to all six through the address byte
      for (int i = 1; i <= 6; i++) begin
         send(sra_pkg::OP_WREN);
         chk_byte({7'h0, write_enable_latch}, 8'h01);
         host_u.frame({sra_pkg::OP_WR_IND, 8'(i), vals[i-1]}, 3, 0, rx);
         chk_byte({7'h0, write_enable_latch}, 8'h00);
         rd_reg(8'(i), v);
         chk_byte(v, exp_of(i, vals[i-1]));
      end
      for (int i = 0; i < 3; i++) begin
         rd_dir(i, v);
         chk_byte(v, exp_of(i + 1, vals[i]));
      end
      $display("test indirect_stored done");
      // Write without an armed enable is dropped
      oe0 = oe_cycles;
      wr_dir(0, 8'hFC);
      chk_byte(8'(oe_cycles - oe0), 8'h00);
      rd_dir(0, v);
      chk_byte(v, exp_of(1, vals[0]));
      $display("test refused_write done");
      // Live-only writes through both paths
      for (int i = 0; i < 6; i++) begin
         send(sra_pkg::OP_VWREN);
         chk_byte({7'h0, write_enable_latch}, 8'h00);
         if (i < 3)
            wr_dir(i, ~vals[i]);
         else
            host_u.frame({sra_pkg::OP_WR_IND, 8'(i + 1), ~vals[i]}, 3, 0, rx);
      end
      for (int i = 0; i < 6; i++) begin
         if (i < 3)
            rd_dir(i, v);
         else
            rd_reg(8'(i + 1), v);
         chk_byte(v, exp_of(i + 1, ~vals[i]));
      end
      $display("test volatile_write done");
      // Undefined addresses, one differing from 01h only in the top bit
      wr_reg(8'h81, sra_pkg::OP_WREN, 8'hFF);
      wr_reg(8'h00, sra_pkg::OP_VWREN, 8'hFF);
      rd_dir(0, v);
      chk_byte(v, exp_of(1, ~vals[0]));
      rd_reg(8'h81, v);
      chk_byte(v, 8'h00);
      rd_reg(8'hFF, v);
      chk_byte(v, 8'h00);
      $display("test unmapped done");
      // Polling returns the same byte on each further eight clocks
      host_u.frame({sra_pkg::OP_RD_SR2, 16'h0000}, 1, 2, rx);
      chk_byte(rx[15:8], ~vals[1]);
      chk_byte(rx[7:0], ~vals[1]);
      $display("test polling done");
      // Protection fields of register one
      send(sra_pkg::OP_VWREN);
      wr_dir(0, 8'hE4);
      chk_prot(prot, 9'b0_1_0_1_1_001_1);
      @(posedge mclk);
      #1 wp_n = 1'b1;
      status_protect_high = 1'b1;
      send(sra_pkg::OP_VWREN);
      wr_dir(0, 8'h08);
      chk_prot(prot, 9'b1_0_1_0_0_010_0);
      $display("test protect_fields done");
      // Live values are lost on reset and reloaded from the stored copy
      do_reset();
      for (int i = 1; i <= 6; i++) begin
         rd_reg(8'(i), v);
         chk_byte(v, exp_of(i, vals[i-1]));
      end
      $display("test reset_reload done");
      print_verdict();
   end
endmodule
